// File: core/bms_pkg.sv
package bms_pkg;

  // Clock rate and the timing figures in their own units
  localparam int CLK_PERIOD_PS         = 5000;
  localparam int BOOT_PULSE_DURATION_US = 1000;
  localparam int HIB_ENTRY_DELAY_NS    = 1000;
  localparam int WAKE_DEGLITCH_TIME_NS = 1000;
  localparam int BOOT_SEQ_CYC          = 64;

  // Cycle counts derived from the figures; least times round up
  localparam int BOOT_PULSE_CYC = (BOOT_PULSE_DURATION_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HIB_DELAY_CYC  = (HIB_ENTRY_DELAY_NS * 1000) / CLK_PERIOD_PS;
  localparam int DEGLITCH_CYC   = (WAKE_DEGLITCH_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W          = 18;
  localparam int DGL_W          = 8;

  // Read map offsets
  localparam logic [7:0] ADDR_STATUS   = 8'h00;
  localparam logic [7:0] ADDR_TEMP     = 8'h01;
  localparam logic [7:0] ADDR_MAG_FST  = 8'h02;
  localparam logic [7:0] ADDR_MAG_SND  = 8'h03;
  localparam logic [7:0] ADDR_AXIS_BEG = 8'h04;

  // Reset values
  localparam logic [7:0] STATUS_RST    = 8'h01;
  localparam logic [7:0] PTR_RST       = 8'h00;

  // Power mode sequencer states
  typedef enum logic [2:0] {
    BMS_OFF       = 3'b000,
    BMS_BOOT      = 3'b001,
    BMS_PULSE     = 3'b010,
    BMS_STANDBY   = 3'b011,
    BMS_ACTIVE    = 3'b100,
    BMS_HIB_WAIT  = 3'b101,
    BMS_HIBERNATE = 3'b110
  } bms_state_e;

  // Configuration bits that steer the read map
  typedef struct packed {
    logic fast_read;
    logic temp_burst_include;
    logic byte_order_select;
    logic magnitude_calc_enable;
  } bms_cfg_s;

  // Whole state of the sequencer
  typedef struct packed {
    bms_state_e       st;
    logic [CNT_W-1:0] cnt;
    logic             strap;
    logic             hib_pend;
    logic             cs_stable;
    logic [DGL_W-1:0] dgl;
    logic [7:0]       ptr;
    logic [7:0]       rdata;
    logic [7:0]       status;
    logic             boot_done;
  } bms_regs_s;

endpackage

// File: core/bms_sequencer.sv
`timescale 1ns/10ps
// Contract
// - After supply is valid the block runs its boot sequence and then gives one boot-done pulse of the set duration.
// - With the boot strap low, every boot, from power-up or wake-up, ends in standby.
// - A hibernate-enable write takes the block into hibernate about 1 us after chip select is released.
// - A deglitched change of the chip-select wake pin takes the block out of hibernate into a new boot and pulse.
// - An active-bit write in standby takes the block into active mode.
// - Address 00h reads the event and status flags, which reset to 01h.
// - Address 01h reads the temperature byte, and bursts skip it when temperature inclusion is off.
// - Address 02h reads magnitude bits 7:0, or bits 11:4 when the byte order bit is set.
// - Bursts skip the magnitude bytes when the magnitude calculation is disabled.
module bms_sequencer
  import bms_pkg::*;
#(
  parameter int BOOT_PULSE = BOOT_PULSE_CYC
)(
  input  wire logic       ref_clk_i,           // System clock, 200 MHz
  input  wire logic       arst_n_i,            // Asynchronous reset, active low
  input  wire logic       supply_ok_i,         // Supply above minimum
  input  wire logic       boot_variant_strap_i,// Boot variant strap level
  input  wire logic       cs_n_i,              // Chip select and wake pin, active low
  input  wire logic       hib_wr_i,            // Host wrote hibernate enable as 1
  input  wire logic       active_wr_i,         // Host wrote active bit as 1
  input  wire bms_cfg_s   cfg_i,               // Read map configuration bits
  input  wire logic [6:0] event_flags_i,       // Event pulses for status bits 7:1
  input  wire logic [7:0] temp_value_i,        // Die temperature result
  input  wire logic [11:0] magnitude_i,        // Unsigned vector magnitude
  input  wire logic       rd_start_i,          // Start a read at rd_addr_i
  input  wire logic       rd_next_i,           // Advance to next burst byte
  input  wire logic [7:0] rd_addr_i,           // Start address of a read
  output logic [7:0]      rd_data_o,           // Byte at the pointer
  output logic [7:0]      rd_ptr_o,            // Current register pointer
  output logic            boot_done_o,         // Boot-done pulse
  output bms_state_e      mode_o               // Present power mode
);

  logic      rst_q1;
  logic      rst_q2;
  bms_regs_s r;
  bms_regs_s n;
  logic      boot_evt;
  logic      rd_clear;

  // Next burst address; skipped registers are stepped over here
  function automatic logic [7:0] next_addr(input logic [7:0] a, input bms_cfg_s c);
    logic [7:0] after_temp;
    after_temp = c.magnitude_calc_enable ? ADDR_MAG_FST : ADDR_AXIS_BEG;
    unique case (a)
      ADDR_STATUS:  next_addr = c.temp_burst_include ? ADDR_TEMP : after_temp;
      ADDR_TEMP:    next_addr = after_temp;
      // The second magnitude byte is skipped too when the calculation is off
      ADDR_MAG_FST: next_addr = (c.fast_read || !c.magnitude_calc_enable) ? ADDR_AXIS_BEG : ADDR_MAG_SND;
      default:      next_addr = a + 8'h01;
    endcase
  endfunction

  // Byte seen at an address; unmapped addresses read zero
  function automatic logic [7:0] read_byte(input logic [7:0] a, input bms_cfg_s c, input logic [7:0] st,
                                           input logic [7:0] t, input logic [11:0] m);
    unique case (a)
      ADDR_STATUS:  read_byte = st;
      ADDR_TEMP:    read_byte = t;
      ADDR_MAG_FST: read_byte = c.byte_order_select ? m[11:4] : m[7:0];
      ADDR_MAG_SND: read_byte = c.byte_order_select ? {4'h0, m[3:0]} : {4'h0, m[11:8]};
      default:      read_byte = 8'h00;
    endcase
  endfunction

  // Reset release through two flops, assertion stays asynchronous
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end

  // Next state of the whole block
  always_comb
  begin
    n        = r;
    boot_evt = 1'b0;
    unique case (r.st)
      BMS_OFF:
      begin
        if (supply_ok_i)
        begin
          n.st    = BMS_BOOT;
          n.cnt   = '0;
          n.strap = boot_variant_strap_i; // Strap caught on leaving reset or power-down
        end
      end
      BMS_BOOT:
      begin
        n.cnt = r.cnt + CNT_W'(1);
        if (r.cnt == CNT_W'(BOOT_SEQ_CYC - 1))
        begin
          n.st  = BMS_PULSE;
          n.cnt = '0;
        end
      end
      BMS_PULSE:
      begin
        n.cnt = r.cnt + CNT_W'(1);
        if (r.cnt == CNT_W'(BOOT_PULSE - 1))
        begin
          n.st     = r.strap ? BMS_HIBERNATE : BMS_STANDBY;
          n.cnt    = '0;
          boot_evt = 1'b1;
          n.cs_stable = cs_n_i;
          n.dgl    = '0;
        end
      end
      BMS_STANDBY, BMS_ACTIVE:
      begin
        if (hib_wr_i)
          n.hib_pend = 1'b1;
        if (r.st == BMS_STANDBY && active_wr_i && !hib_wr_i)
          n.st = BMS_ACTIVE;
        // Entry waits for chip select to rise, so the write itself completes
        if (r.hib_pend && cs_n_i)
        begin
          n.st       = BMS_HIB_WAIT;
          n.cnt      = '0;
          n.hib_pend = 1'b0;
        end
      end
      BMS_HIB_WAIT:
      begin
        n.cnt = r.cnt + CNT_W'(1);
        if (r.cnt == CNT_W'(HIB_DELAY_CYC - 1))
        begin
          n.st        = BMS_HIBERNATE;
          n.cnt       = '0;
          n.cs_stable = cs_n_i;
          n.dgl       = '0;
        end
      end
      BMS_HIBERNATE:
      begin
        // A short glitch restarts the filter instead of waking the block
        if (cs_n_i != r.cs_stable)
        begin
          n.dgl = r.dgl + DGL_W'(1);
          if (r.dgl == DGL_W'(DEGLITCH_CYC - 1))
          begin
            n.st  = BMS_BOOT;
            n.cnt = '0;
            n.dgl = '0;
          end
        end
        else
          n.dgl = '0;
      end
      default:
        n.st = BMS_OFF;
    endcase
    // Loss of supply wins over every mode
    if (!supply_ok_i)
    begin
      n.st       = BMS_OFF;
      n.hib_pend = 1'b0;
    end
    n.boot_done = (n.st == BMS_PULSE);
    // Register pointer and read data
    if (rd_start_i)
      n.ptr = rd_addr_i;
    else if (rd_next_i)
      n.ptr = next_addr(r.ptr, cfg_i);
    n.rdata  = read_byte(n.ptr, cfg_i, r.status, temp_value_i, magnitude_i);
    rd_clear = (rd_start_i || rd_next_i) && (n.ptr == ADDR_STATUS);
    // Flags clear on read; a new event in the same cycle still sets
    if (rd_clear)
      n.status = 8'h00;
    n.status = n.status | {event_flags_i, boot_evt};
  end

  // Single state register
  always_ff @(posedge ref_clk_i or negedge rst_q2)
  begin
    if (!rst_q2)
    begin
      r        <= '0;
      r.st     <= BMS_OFF;
      r.ptr    <= PTR_RST;
      r.status <= STATUS_RST;
    end
    else
      r <= n;
  end

  assign rd_data_o   = r.rdata;
  assign rd_ptr_o    = r.ptr;
  assign boot_done_o = r.boot_done;
  assign mode_o      = r.st;

  // Helper: length of the present boot-done pulse
  logic [CNT_W-1:0] pulse_len;
  always_ff @(posedge ref_clk_i or negedge rst_q2)
  begin
    if (!rst_q2)
      pulse_len <= '0;
    else
      pulse_len <= boot_done_o ? pulse_len + CNT_W'(1) : '0;
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_q2);

  // Supply is judged one cycle back, since its loss is what cuts a pulse short
  AST_PULSE_LEN: assert property ($fell(boot_done_o) && $past(supply_ok_i) |-> pulse_len == CNT_W'(BOOT_PULSE))
    else $error("boot-done pulse has the wrong length");
  AST_STANDBY_AFTER_BOOT: assert property ($fell(boot_done_o) && $past(supply_ok_i) && !r.strap
                                           |-> mode_o == BMS_STANDBY)
    else $error("boot did not end in standby");
  AST_HIB_DELAY: assert property ($rose(mode_o == BMS_HIBERNATE) && $past(mode_o) == BMS_HIB_WAIT |->
                                  $past(mode_o, 200) == BMS_HIB_WAIT && $past(mode_o, 201) != BMS_HIB_WAIT)
    else $error("hibernate entry delay is wrong");
  AST_WAKE_FILTER: assert property (r.st == BMS_HIBERNATE && cs_n_i == r.cs_stable |=> r.st != BMS_BOOT)
    else $error("wake taken without a stable pin change");
  AST_ACTIVE: assert property (r.st == BMS_STANDBY && active_wr_i && !hib_wr_i && !r.hib_pend && supply_ok_i
                               |=> mode_o == BMS_ACTIVE)
    else $error("active write did not enter active mode");
  AST_STATUS_READ: assert property (rd_start_i && rd_addr_i == ADDR_STATUS |=> rd_data_o == $past(r.status))
    else $error("status read returned the wrong byte");
  AST_TEMP_SKIP: assert property (rd_next_i && !rd_start_i && !cfg_i.temp_burst_include |=> rd_ptr_o != ADDR_TEMP)
    else $error("burst did not skip temperature");
  AST_MAG_ORDER: assert property (rd_start_i && rd_addr_i == ADDR_MAG_FST && cfg_i.byte_order_select
                                  |=> rd_data_o == $past(magnitude_i[11:4]))
    else $error("magnitude byte order wrong");
  AST_MAG_SKIP: assert property (rd_next_i && !rd_start_i && !cfg_i.magnitude_calc_enable &&
                                 (rd_ptr_o == ADDR_TEMP || (rd_ptr_o == ADDR_STATUS && !cfg_i.temp_burst_include))
                                 |=> rd_ptr_o == ADDR_AXIS_BEG)
    else $error("burst did not skip magnitude");
  AST_FAST_READ: assert property (rd_next_i && !rd_start_i && rd_ptr_o == ADDR_MAG_FST && cfg_i.fast_read
                                  |=> rd_ptr_o == ADDR_AXIS_BEG)
    else $error("fast read advanced to the wrong address");

endmodule

// File: bench/bms_host_model.sv
`timescale 1ns/10ps
module bms_host_model (
  input  wire logic       ref_clk_i,   // System clock
  output logic            cs_n_o,      // Chip select and wake pin, active low
  output logic            hib_wr_o,    // Hibernate enable written as 1
  output logic            active_wr_o, // Active bit written as 1
  output logic            rd_start_o,  // Start a read
  output logic            rd_next_o,   // Advance a burst
  output logic [7:0]      rd_addr_o    // Read start address
);
  // Idle host: deselected, no strobes
  initial
  begin
    cs_n_o      = 1'b1;
    hib_wr_o    = 1'b0;
    active_wr_o = 1'b0;
    rd_start_o  = 1'b0;
    rd_next_o   = 1'b0;
    rd_addr_o   = 8'h00;
  end

  // Lines change just after an edge so the block never samples a moving input
  task automatic step();
    @(posedge ref_clk_i);
    #1;
  endtask

  // Hibernate write: strobe inside the select, then release the select
  task automatic write_hib();
    step();
    cs_n_o   = 1'b0;
    hib_wr_o = 1'b1;
    step();
    hib_wr_o = 1'b0;
    step();
    cs_n_o   = 1'b1;
  endtask

  // Active write, one strobe cycle
  task automatic write_active();
    step();
    active_wr_o = 1'b1;
    step();
    active_wr_o = 1'b0;
  endtask

  // Wake toggle held low for the given cycles; a short hold is a glitch
  task automatic wake(input int cycles);
    step();
    cs_n_o = 1'b0;
    repeat (cycles) step();
    cs_n_o = 1'b1;
  endtask

  // Read start; the address is scrambled once it has been taken
  task automatic rd_start(input logic [7:0] addr);
    step();
    rd_start_o = 1'b1;
    rd_addr_o  = addr;
    step();
    rd_start_o = 1'b0;
    rd_addr_o  = ~addr;
  endtask

  task automatic rd_next();
    step();
    rd_next_o = 1'b1;
    step();
    rd_next_o = 1'b0;
  endtask
endmodule

// File: bench/testbench.sv
`timescale 1ns/10ps
module testbench;
  import bms_pkg::*;
  localparam int PULSE = 20;
  logic        ref_clk   = 1'b0;
  logic        arst_n    = 1'b0;
  logic        supply_ok = 1'b1;
  logic        strap     = 1'b0;
  logic        cs_n, hib_wr, active_wr, rd_start, rd_next, boot_done;
  logic [7:0]  rd_addr, rd_data, rd_ptr;
  logic [7:0]  temp      = 8'hA5;
  logic [11:0] mag       = 12'hC3E;
  logic [6:0]  events    = 7'h00;
  bms_cfg_s    cfg       = '0;
  bms_state_e  mode;
  int          n_errors  = 0;
  int          num_checks = 0;

  always #2.5 ref_clk = ~ref_clk;

  bms_host_model host (.ref_clk_i(ref_clk), .cs_n_o(cs_n), .hib_wr_o(hib_wr), .active_wr_o(active_wr),
                       .rd_start_o(rd_start), .rd_next_o(rd_next), .rd_addr_o(rd_addr));

  bms_sequencer #(.BOOT_PULSE(PULSE)) dut (
    .ref_clk_i(ref_clk), .arst_n_i(arst_n), .supply_ok_i(supply_ok), .boot_variant_strap_i(strap),
    .cs_n_i(cs_n), .hib_wr_i(hib_wr), .active_wr_i(active_wr), .cfg_i(cfg), .event_flags_i(events),
    .temp_value_i(temp), .magnitude_i(mag), .rd_start_i(rd_start), .rd_next_i(rd_next),
    .rd_addr_i(rd_addr), .rd_data_o(rd_data), .rd_ptr_o(rd_ptr), .boot_done_o(boot_done), .mode_o(mode));

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("Checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Bounded wait for a mode; running out ends the run
  task automatic wait_mode(input bms_state_e st, input int bound);
    for (int i = 0; i < bound && mode !== st; i++)
      host.step();
    if (mode !== st)
    begin
      n_errors++;
      $display("Error mode wait expected %h seen %h", st, mode);
      complete_run();
    end
  endtask

  // Next burst address, worked out from the skip rules
  function automatic logic [7:0] nxt(input logic [7:0] p, input bms_cfg_s c);
    if (p == 8'h00 && c.temp_burst_include)
      return 8'h01;
    if (p <= 8'h01)
      return c.magnitude_calc_enable ? 8'h02 : 8'h04;
    if (p == 8'h02)
      return (c.fast_read || !c.magnitude_calc_enable) ? 8'h04 : 8'h03;
    return p + 8'h01;
  endfunction

  // Boot ends with exactly one pulse of the set length, then standby
  task automatic t_boot();
    int n;
    wait_mode(BMS_PULSE, BOOT_SEQ_CYC + 8);
    for (n = 0; n < 4 * PULSE && boot_done === 1'b1; n++)
      host.step();
    check("boot pulse cycles", 12'(n), 12'(PULSE));
    check("mode after boot", 12'(mode), 12'(BMS_STANDBY));
  endtask

  // Status resets to 01h, clears on read, then shows event bits
  task automatic t_status();
    host.rd_start(8'h00);
    check("status first read", 12'(rd_data), 12'h001);
    host.rd_start(8'h00);
    check("status after clear", 12'(rd_data), 12'h000);
    events = 7'h05;
    host.step();
    events = 7'h00;
    host.rd_start(8'h00);
    check("status events", 12'(rd_data), 12'h00A);
  endtask

  // Temperature and both byte orders of the magnitude
  task automatic t_map();
    host.rd_start(8'h01);
    check("temperature byte", 12'(rd_data), 12'(temp));
    host.rd_start(8'h02);
    check("magnitude low order", 12'(rd_data), 12'(mag[7:0]));
    cfg.byte_order_select = 1'b1;
    host.rd_start(8'h02);
    check("magnitude high order", 12'(rd_data), 12'(mag[11:4]));
    // New data values must show up on the next read
    temp = 8'h5C;
    mag  = 12'h4B7;
    host.rd_start(8'h01);
    check("temperature byte new", 12'(rd_data), 12'(temp));
    host.rd_start(8'h02);
    check("magnitude high order new", 12'(rd_data), 12'(mag[11:4]));
  endtask

  // Every configuration: three burst steps from 00h
  task automatic t_burst();
    logic [7:0] p;
    for (int i = 0; i < 16; i++)
    begin
      cfg = bms_cfg_s'(i[3:0]);
      host.rd_start(8'h00);
      p = 8'h00;
      repeat (3)
      begin
        p = nxt(p, cfg);
        host.rd_next();
        check("burst pointer", 12'(rd_ptr), 12'(p));
      end
    end
    // A burst started on the first magnitude byte skips the second when disabled
    cfg = '0;
    host.rd_start(8'h02);
    host.rd_next();
    check("burst from magnitude disabled", 12'(rd_ptr), 12'h004);
  endtask

  // Hibernate entry after the select is released, glitch refused, wake reboots
  task automatic t_hib();
    host.write_hib();
    wait_mode(BMS_HIB_WAIT, 3);
    repeat (HIB_DELAY_CYC - 10) host.step();
    check("mode before hibernate", 12'(mode), 12'(BMS_HIB_WAIT));
    wait_mode(BMS_HIBERNATE, 20);
    host.wake(DEGLITCH_CYC - 20);
    repeat (5) host.step();
    check("mode after glitch", 12'(mode), 12'(BMS_HIBERNATE));
    host.wake(DEGLITCH_CYC + 20);
    t_boot();
  endtask

  task automatic t_active();
    host.write_active();
    check("mode after active write", 12'(mode), 12'(BMS_ACTIVE));
  endtask

  // Supply loss forces off; the strap high variant then ends its boot in hibernate
  task automatic t_power();
    supply_ok = 1'b0;
    strap     = 1'b1;
    repeat (4) host.step();
    check("mode without supply", 12'(mode), 12'(BMS_OFF));
    supply_ok = 1'b1;
    wait_mode(BMS_PULSE, BOOT_SEQ_CYC + 8);
    check("boot done with strap high", 12'(boot_done), 12'h001);
    wait_mode(BMS_HIBERNATE, 4 * PULSE);
    check("mode after strap high boot", 12'(mode), 12'(BMS_HIBERNATE));
  endtask

  initial
  begin
    repeat (16) host.step();
    check("mode in reset", 12'(mode), 12'(BMS_OFF));
    check("pointer in reset", 12'(rd_ptr), 12'h000);
    arst_n = 1'b1;
    t_boot();
    t_status();
    t_map();
    t_burst();
    t_hib();
    t_active();
    t_power();
    complete_run();
  end
endmodule
